// ===== verilog/rxch_map.vh
// Constants for the resolver explicit command handler
`ifndef RXCH_MAP_VH
`define RXCH_MAP_VH

// ****************************************************************
// Service codes
// ****************************************************************
`define RXCH_SVC_RESET       8'h05
`define RXCH_SVC_GET_SINGLE  8'h0E
`define RXCH_SVC_SET_SINGLE  8'h10
`define RXCH_SVC_RESTORE     8'h15
`define RXCH_SVC_SAVE        8'h16

// ****************************************************************
// Addressing
// ****************************************************************
`define RXCH_CLASS_POS       8'h23
`define RXCH_CLASS_IDENT     8'h01
`define RXCH_INST_CLASS      8'h00
`define RXCH_INST_ONE        8'h01
`define RXCH_ATTR_REV        8'h01
`define RXCH_ATTR_PRESET     8'h13
`define RXCH_LEN_NONE        8'h00
`define RXCH_LEN_PRESET      8'h04

// ****************************************************************
// Object revision and answer status codes
// ****************************************************************
`define RXCH_OBJ_REVISION    32'h0000_0002
`define RXCH_ST_OK           8'h00
`define RXCH_ST_BAD_SVC      8'h08
`define RXCH_ST_BAD_ATTR     8'h14
`define RXCH_ST_BAD_DATA     8'h09
`define RXCH_ST_BAD_PATH     8'h05
`define RXCH_ST_BAD_LEN      8'h15

// ****************************************************************
// Timing
// ****************************************************************
`define RXCH_CLK_MHZ         125
`define RXCH_RST_PULSE_NS    800
`define RXCH_RST_PULSE_CYC   ((`RXCH_RST_PULSE_NS * `RXCH_CLK_MHZ) / 1000)

`endif

// ===== verilog/rxch_byte_pack.v
// Little-endian gatherer of the four preset bytes
`timescale 1ns/100ps
module rxch_byte_pack (
  core_clk,
  sys_rst,
  clear,
  byte_valid,
  byte_data,
  word,
  count
);
  input  wire        core_clk;
  input  wire        sys_rst;
  input  wire        clear;
  input  wire        byte_valid;
  input  wire [7:0]  byte_data;
  output reg  [31:0] word;
  output reg  [7:0]  count;

  always @(posedge core_clk) begin
    if (sys_rst || clear) begin
      word  <= 32'h0000_0000;
      count <= 8'h00;
    end else if (byte_valid) begin
      // First byte lands in bits 7:0, fourth in bits 31:24
      case (count)
        8'h00: word[7:0]   <= byte_data;
        8'h01: word[15:8]  <= byte_data;
        8'h02: word[23:16] <= byte_data;
        8'h03: word[31:24] <= byte_data;
        default: word <= word;
      endcase
      // Saturate so an oversize payload is still seen as too long
      if (count != 8'hFF)
        count <= count + 8'h01;
    end
  end
endmodule

// ===== verilog/rxch_cmd.v
// Explicit command decoder and executor for the resolver
`timescale 1ns/100ps
`include "rxch_map.vh"

// Behaviour
// - Preset is set-single, class 23h, instance 1, attribute 13h, four bytes.
// - Preset recomputes the offset, held only in volatile storage.
// - Preset bytes form one word, least significant byte first.
// - Save 16h to class 23h instance 0 copies parameters and offset to flash.
// - Restore 15h to class 23h instance 0 reloads parameters from flash.
// - Reset 5 to class 23h instance 0 sets factory defaults.
// - Reset 5 to class 1 instance 1 forces hardware reset, reload from flash.
// - Position object revision two is reported at class attribute one.
module rxch_cmd (
  core_clk,
  sys_rst,
  req_start,
  req_service,
  req_class,
  req_instance,
  req_attribute,
  req_length,
  req_byte_valid,
  req_byte,
  req_end,
  cur_position,
  full_scale,
  flash_offset,
  flash_done,
  pos_offset,
  rsp_valid,
  rsp_status,
  rsp_data,
  save_req,
  restore_req,
  defaults_req,
  hw_reset_req
);
  input  wire        core_clk;
  input  wire        sys_rst;
  input  wire        req_start;
  input  wire [7:0]  req_service;
  input  wire [7:0]  req_class;
  input  wire [7:0]  req_instance;
  input  wire [7:0]  req_attribute;
  input  wire [7:0]  req_length;
  input  wire        req_byte_valid;
  input  wire [7:0]  req_byte;
  input  wire        req_end;
  input  wire [31:0] cur_position;
  input  wire [31:0] full_scale;
  input  wire [31:0] flash_offset;
  input  wire        flash_done;
  output reg  [31:0] pos_offset;
  output reg         rsp_valid;
  output reg  [7:0]  rsp_status;
  output reg  [31:0] rsp_data;
  output reg         save_req;
  output reg         restore_req;
  output reg         defaults_req;
  output reg         hw_reset_req;

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_DATA  = 3'd1;
  localparam [2:0] ST_EXEC  = 3'd2;
  localparam [2:0] ST_FLASH = 3'd3;
  localparam [2:0] ST_HWRST = 3'd4;

  localparam [2:0] OP_NONE     = 3'd0;
  localparam [2:0] OP_PRESET   = 3'd1;
  localparam [2:0] OP_SAVE     = 3'd2;
  localparam [2:0] OP_RESTORE  = 3'd3;
  localparam [2:0] OP_DEFAULTS = 3'd4;
  localparam [2:0] OP_HWRESET  = 3'd5;
  localparam [2:0] OP_GETREV   = 3'd6;

  // Pulse length is well under 256 cycles, so the low byte carries all of it
  localparam integer RST_CYC_I = `RXCH_RST_PULSE_CYC;
  localparam [7:0]   RST_CYC   = RST_CYC_I[7:0];

  reg [2:0]  state_q;
  reg [2:0]  op_q;
  reg [7:0]  len_q;
  reg [7:0]  err_q;
  reg [7:0]  rst_cnt_q;
  reg [7:0]  status_d;
  reg [2:0]  op_d;
  wire [31:0] pack_word;
  wire [7:0]  pack_count;

  // ****************************************************************
  // Request classification
  // ****************************************************************
  function [2:0] rxch_classify;
    input [7:0] svc;
    input [7:0] cls;
    input [7:0] inst;
    input [7:0] attr;
    input [7:0] len;
    begin
      rxch_classify = OP_NONE;
      if (svc == `RXCH_SVC_SET_SINGLE && cls == `RXCH_CLASS_POS &&
          inst == `RXCH_INST_ONE && attr == `RXCH_ATTR_PRESET &&
          len == `RXCH_LEN_PRESET)
        rxch_classify = OP_PRESET;
      else if (len == `RXCH_LEN_NONE) begin
        // Attribute is not compared for save, restore and reset services
        if (cls == `RXCH_CLASS_POS && inst == `RXCH_INST_CLASS) begin
          case (svc)
            `RXCH_SVC_SAVE:    rxch_classify = OP_SAVE;
            `RXCH_SVC_RESTORE: rxch_classify = OP_RESTORE;
            `RXCH_SVC_RESET:   rxch_classify = OP_DEFAULTS;
            `RXCH_SVC_GET_SINGLE:
              if (attr == `RXCH_ATTR_REV)
                rxch_classify = OP_GETREV;
            default: rxch_classify = OP_NONE;
          endcase
        end else if (svc == `RXCH_SVC_RESET && cls == `RXCH_CLASS_IDENT &&
                     inst == `RXCH_INST_ONE)
          rxch_classify = OP_HWRESET;
      end
    end
  endfunction

  always @* begin
    op_d     = rxch_classify(req_service, req_class, req_instance,
                             req_attribute, req_length);
    status_d = `RXCH_ST_OK;
    if (op_d == OP_NONE) begin
      if (req_class != `RXCH_CLASS_POS && req_class != `RXCH_CLASS_IDENT)
        status_d = `RXCH_ST_BAD_PATH;
      else if (req_service == `RXCH_SVC_SET_SINGLE &&
               req_attribute == `RXCH_ATTR_PRESET)
        status_d = `RXCH_ST_BAD_LEN;
      else if (req_service == `RXCH_SVC_GET_SINGLE ||
               req_service == `RXCH_SVC_SET_SINGLE)
        status_d = `RXCH_ST_BAD_ATTR;
      else
        status_d = `RXCH_ST_BAD_SVC;
    end
  end

  rxch_byte_pack u_pack (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .clear      (req_start && state_q == ST_IDLE),
    .byte_valid (req_byte_valid && state_q == ST_DATA),
    .byte_data  (req_byte),
    .word       (pack_word),
    .count      (pack_count)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always @(posedge core_clk) begin
    if (sys_rst) begin
      state_q      <= ST_IDLE;
      op_q         <= OP_NONE;
      len_q        <= 8'h00;
      err_q        <= 8'h00;
      rst_cnt_q    <= 8'h00;
      pos_offset   <= 32'h0000_0000;
      rsp_valid    <= 1'b0;
      rsp_status   <= 8'h00;
      rsp_data     <= 32'h0000_0000;
      save_req     <= 1'b0;
      restore_req  <= 1'b0;
      defaults_req <= 1'b0;
      hw_reset_req <= 1'b0;
    end else begin
      rsp_valid    <= 1'b0;
      save_req     <= 1'b0;
      restore_req  <= 1'b0;
      defaults_req <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (req_start) begin
            op_q    <= op_d;
            err_q   <= status_d;
            len_q   <= req_length;
            state_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (req_end)
            state_q <= ST_EXEC;
        end
        ST_EXEC: begin
          state_q    <= ST_IDLE;
          rsp_valid  <= 1'b1;
          rsp_status <= err_q;
          rsp_data   <= 32'h0000_0000;
          // Byte count actually received must match the header length
          if (pack_count != len_q) begin
            rsp_status <= `RXCH_ST_BAD_LEN;
          end else begin
            case (op_q)
              OP_PRESET: begin
                // Range limit is the requester's duty; out of range is refused
                if (pack_word > full_scale)
                  rsp_status <= `RXCH_ST_BAD_DATA;
                else
                  pos_offset <= pack_word - cur_position;
              end
              OP_GETREV:   rsp_data <= `RXCH_OBJ_REVISION;
              OP_SAVE: begin
                rsp_valid <= 1'b0;
                save_req  <= 1'b1;
                state_q   <= ST_FLASH;
              end
              OP_RESTORE: begin
                rsp_valid   <= 1'b0;
                restore_req <= 1'b1;
                state_q     <= ST_FLASH;
              end
              OP_DEFAULTS: defaults_req <= 1'b1;
              OP_HWRESET: begin
                // Answer first, then pull the reset so the reply can leave
                rst_cnt_q <= RST_CYC;
                state_q   <= ST_HWRST;
              end
              default: rsp_status <= err_q;
            endcase
          end
        end
        ST_FLASH: begin
          if (flash_done) begin
            if (op_q == OP_RESTORE)
              pos_offset <= flash_offset;
            rsp_valid  <= 1'b1;
            rsp_status <= `RXCH_ST_OK;
            state_q    <= ST_IDLE;
          end
        end
        ST_HWRST: begin
          hw_reset_req <= 1'b1;
          if (rst_cnt_q == 8'h00) begin
            hw_reset_req <= 1'b0;
            state_q      <= ST_IDLE;
          end else
            rst_cnt_q <= rst_cnt_q - 8'h01;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// ===== test/rxch_cmd_sva.sv
// Port assertions for the command handler
`timescale 1ns/100ps
`include "rxch_map.vh"
module rxch_cmd_sva (
  input wire        core_clk,
  input wire        sys_rst,
  input wire        req_start,
  input wire [7:0]  req_service,
  input wire [7:0]  req_class,
  input wire [7:0]  req_instance,
  input wire [7:0]  req_attribute,
  input wire [7:0]  req_length,
  input wire        req_byte_valid,
  input wire        req_end,
  input wire        flash_done,
  input wire [31:0] pos_offset,
  input wire        rsp_valid,
  input wire [7:0]  rsp_status,
  input wire [31:0] rsp_data,
  input wire        save_req,
  input wire        restore_req,
  input wire        defaults_req,
  input wire        hw_reset_req
);
  // ****************
  // Header decode
  // ****************
  wire       hd  = req_start && req_length == 8'h00;
  wire       cl0 = req_class == 8'h23 && req_instance == 8'h00;
  reg  [7:0] hw_cnt_q;
  always @(posedge core_clk) begin
    if (sys_rst || !hw_reset_req) hw_cnt_q <= 8'h00;
    else hw_cnt_q <= hw_cnt_q + 8'h01;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_PRESET: assert property (req_start && req_service == 8'h10 && req_class == 8'h23
    && req_instance == 8'h01 && req_attribute == 8'h13 && req_length == 8'h04
    ##1 req_byte_valid [*4] ##1 req_end |-> ##2 rsp_valid) else $error("preset unanswered");
  AST_SAVE: assert property (hd && cl0 && req_service == 8'h16 ##1 req_end
    |-> ##2 save_req) else $error("save not started");
  AST_REST: assert property (hd && cl0 && req_service == 8'h15 ##1 req_end
    |-> ##2 restore_req) else $error("restore not started");
  AST_FLASH: assert property (flash_done |=> rsp_valid && rsp_status == 8'h00)
    else $error("flash end not answered");
  AST_DEF: assert property (hd && cl0 && req_service == 8'h05 ##1 req_end
    |-> ##[2:3] defaults_req) else $error("defaults not raised");
  AST_HWR: assert property (hd && req_service == 8'h05 && req_class == 8'h01
    && req_instance == 8'h01 ##1 req_end |-> ##2 rsp_valid && rsp_status == 8'h00
    ##1 hw_reset_req) else $error("hardware reset not raised");
  AST_HWLEN: assert property ($fell(hw_reset_req) |-> hw_cnt_q == `RXCH_RST_PULSE_CYC)
    else $error("reset pulse length wrong");
  AST_REV: assert property (hd && cl0 && req_service == 8'h0E && req_attribute == 8'h01
    ##1 req_end |-> ##2 rsp_valid && rsp_data == 32'h2) else $error("revision wrong");
  AST_ERR: assert property (rsp_valid && rsp_status != 8'h00 |-> $stable(pos_offset))
    else $error("refused request moved offset");
  AST_PULSE: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than a cycle");
endmodule
bind rxch_cmd rxch_cmd_sva chk_u (.*);

// ===== test/rxch_flash_mdl.sv
// Flash store model answering save and restore
`timescale 1ns/100ps
module rxch_flash_mdl (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire        save_req,
  input  wire        restore_req,
  input  wire [31:0] pos_offset,
  input  wire [2:0]  fl_delay,
  output reg         flash_done,
  output reg  [31:0] flash_offset
);
  reg [31:0] saved_q;
  reg [3:0]  wait_q;
  reg        rest_q;
  always @(posedge core_clk) begin
    flash_done <= 1'b0;
    // Outside the answer the bus shows no stale copy
    flash_offset <= ~saved_q;
    if (sys_rst) begin
      wait_q <= 4'h0;
      saved_q <= 32'h0;
      rest_q <= 1'b0;
    end else if (save_req || restore_req) begin
      wait_q <= {1'b0, fl_delay} + 4'h1;
      rest_q <= restore_req;
      if (save_req) saved_q <= pos_offset;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
      flash_done <= wait_q == 4'h1;
      if (wait_q == 4'h1 && rest_q) flash_offset <= saved_q;
    end
  end
endmodule

// ===== test/test_rxch_cmd.sv
// Self-checking bench for the command handler
`timescale 1ns/100ps
`include "rxch_map.vh"
module test_rxch_cmd;
  reg         core_clk = 1'b0, sys_rst = 1'b1, req_start = 1'b0;
  reg         req_byte_valid = 1'b0, req_end = 1'b0;
  reg  [7:0]  req_service = 8'h00, req_class = 8'h00, req_instance = 8'h00;
  reg  [7:0]  req_attribute = 8'h00, req_length = 8'h00, req_byte = 8'h00;
  reg  [31:0] cur_position = 32'h0, full_scale = 32'h0, lfsr_q = 32'h28;
  reg  [31:0] cp, fs, v, exp_ofs, saved;
  reg  [2:0]  fl_delay = 3'h0;
  wire [31:0] pos_offset, rsp_data, flash_offset;
  wire [7:0]  rsp_status;
  wire        rsp_valid, save_req, restore_req, defaults_req, hw_reset_req, flash_done;
  // Note layout: check offset, status (FF any refusal), data, offset
  reg  [72:0] exp_q[$];
  reg  [72:0] e;
  integer     miscompares = 0, n_checks = 0, n_rsp = 0, t = 0, i, k;
  localparam [39:0] ERR = {8'hFF, 32'h0};
  always #4 core_clk = ~core_clk;
  rxch_cmd dut_u (.*);
  rxch_flash_mdl flash_u (.*);
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task check(input string nm, input [31:0] ex, input [31:0] got);
    n_checks = n_checks + 1;
    if (ex !== got) begin
      miscompares = miscompares + 1;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task rnd;
    lfsr_q = lfsr(lfsr_q);
    cp = lfsr_q;
    lfsr_q = lfsr(lfsr_q);
    fs = {8'h00, lfsr_q[23:0]};
    cur_position <= cp;
    full_scale <= fs;
    fl_delay <= lfsr_q[30:28];
  endtask
  // ****************
  // Request driver
  // ****************
  task req(input [7:0] s, c, n, a, l, input integer nb, input [31:0] d, input [72:0] ex);
    integer r;
    exp_q.push_back(ex);
    r = n_rsp;
    @(posedge core_clk);
    req_service <= s;
    req_class <= c;
    req_instance <= n;
    req_attribute <= a;
    req_length <= l;
    req_start <= 1'b1;
    for (i = 0; i < nb; i = i + 1) begin
      @(posedge core_clk);
      req_start <= 1'b0;
      req_byte_valid <= 1'b1;
      req_byte <= d[8*i +: 8];
    end
    @(posedge core_clk);
    req_start <= 1'b0;
    req_byte_valid <= 1'b0;
    req_end <= 1'b1;
    @(posedge core_clk);
    req_end <= 1'b0;
    for (i = 0; i < 300 && n_rsp == r; i = i + 1) @(posedge core_clk);
    if (n_rsp == r) begin
      miscompares = miscompares + 1;
      $display("BAD response expected 1 seen 0");
      finish_test;
    end else begin
      t = t + 1;
      $display("test %0d done", t);
    end
  endtask
  // Answers are judged where outputs have settled
  always @(negedge core_clk) begin
    if (!sys_rst && rsp_valid === 1'b1) begin
      e = exp_q.pop_front();
      if (e[71:64] == 8'hFF) check("refusal", 1, rsp_status != 8'h00);
      else check("status", e[71:64], rsp_status);
      check("data", e[63:32], rsp_data);
      if (e[72]) check("offset", e[31:0], pos_offset);
      n_rsp = n_rsp + 1;
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    rnd;
    v = lfsr_q % (fs + 32'h1);
    exp_ofs = v - cp;
    req(8'h10, 8'h23, 8'h01, 8'h13, 8'h04, 4, v, {1'b1, 40'h0, exp_ofs});
    req(8'h10, 8'h23, 8'h01, 8'h13, 8'h04, 3, v, {1'b1, ERR, exp_ofs});
    req(8'h10, 8'h23, 8'h01, 8'h13, 8'h04, 4, fs + 32'h1, {1'b1, ERR, exp_ofs});
    saved = exp_ofs;
    req(8'h16, 8'h23, 8'h00, 8'h00, 8'h00, 0, 0, {1'b1, 40'h0, exp_ofs});
    rnd;
    v = lfsr_q % (fs + 32'h1);
    exp_ofs = v - cp;
    req(8'h10, 8'h23, 8'h01, 8'h13, 8'h04, 4, v, {1'b1, 40'h0, exp_ofs});
    exp_ofs = saved;
    req(8'h15, 8'h23, 8'h00, 8'h00, 8'h00, 0, 0, {1'b1, 40'h0, exp_ofs});
    req(8'h16, 8'h23, 8'h01, 8'h00, 8'h00, 0, 0, {1'b1, ERR, exp_ofs});
    req(8'h33, 8'h23, 8'h01, 8'h13, 8'h00, 0, 0, {1'b1, ERR, exp_ofs});
    req(8'h0E, 8'h23, 8'h00, 8'h01, 8'h00, 0, 0, {1'b1, 8'h00, 32'h2, exp_ofs});
    req(8'h05, 8'h23, 8'h00, 8'h5A, 8'h00, 0, 0, 73'h0);
    req(8'h05, 8'h01, 8'h01, 8'h00, 8'h00, 0, 0, 73'h0);
    k = 0;
    for (i = 0; i < 200; i = i + 1) begin
      @(negedge core_clk);
      if (hw_reset_req === 1'b1) k = k + 1;
    end
    check("reset pulse", `RXCH_RST_PULSE_CYC, k);
    finish_test;
  end
endmodule
